// *** logic/tsv_defines.svh ***
`ifndef TSV_DEFINES_SVH
`define TSV_DEFINES_SVH
// Overview of operation
// - key detected longer than its negative recal delay is recalibrated
// - negative recal delay of zero never times out; host recal still works
// - negative recal delay byte 0..254 in 0.5 s units, default 20, never 255
// - signal above positive threshold for whole positive delay forces recal
// - positive recal delay fixed at 200 ms within 50 ms, not settable
// - each burst cycle pulses drive line once with receive line enabled
// - burst length code 0..3 selects 16/32/48/64 cycles, default 2
// - suppressed key loses detection if another such key deviates more negatively
// - suppression enable resets off; comparison uses raw deviation only
// - scope sync is high during bursts of keys with sync bit set
// - mains sync waits up to 100 ms before first enabled key, then scans
// - without sync edges the scan still runs after a full 100 ms wait
// - mains sync enable is one bit, 1 on, reset off
// - outside fast mode the device sleeps, wakes, scans, sleeps again
// - sleep interval index 0..7 spans 16 ms to 2 s, default 3 is 125 ms
// - wake bit per key, default on; change asserts change output and fast mode
// - while awake any key change restarts the awake interval
// - shift mode: wake on all keys, no change output, 2.5 s awake
// - fast mode scans continuously until awake timeout after last change
// - awake timeout 1..255 in 100 ms units, default 25
// - any new detection halts all drift for hold time, 100 ms units, 0 off
// - key with zero integrator limit is skipped by the burst sequence
// - drift runs only while key is not past its negative threshold
`define TSV_CLK_NS 50
`define TSV_TICK_NS 1000000
`define TSV_ADDR_CTRL 12'h000
`define TSV_ADDR_AWAKE 12'h004
`define TSV_ADDR_DRIFT_HOLD 12'h008
`define TSV_ADDR_STATUS 12'h00c
`define TSV_ADDR_KEYSTATE 12'h010
`define TSV_ADDR_RECAL 12'h014
`define TSV_ADDR_KEYCFG_PAGE 4'h1
`define TSV_CTRL_MAINS_BIT 0
`define TSV_CTRL_SHIFT_BIT 4
`define TSV_CTRL_RST 8'h06
`define TSV_AWAKE_RST 8'h19
`define TSV_DRIFT_HOLD_RST 8'h0a
`define TSV_KEYCFG_RST 16'h5214
`define TSV_NEG_RECAL_MAX 8'hfe
`define TSV_NEG_RECAL_ILLEGAL 8'hff
`define TSV_NEG_RECAL_UNIT_MS 17'd500
`define TSV_POS_RECAL_MS 17'd200
`define TSV_MAINS_WAIT_MS 17'd100
`define TSV_TIME_UNIT_MS 17'd100
`define TSV_SHIFT_AWAKE_MS 17'd2500
`define TSV_BURST_UNIT 7'd16
`define TSV_SLEEP0_MS 17'd16
`define TSV_SLEEP1_MS 17'd32
`define TSV_SLEEP2_MS 17'd64
`define TSV_SLEEP3_MS 17'd125
`define TSV_SLEEP4_MS 17'd250
`define TSV_SLEEP5_MS 17'd500
`define TSV_SLEEP6_MS 17'd1000
`define TSV_SLEEP7_MS 17'd2000
`endif

// *** logic/tsv_pkg.sv ***
package tsv_pkg;
	typedef struct packed {
		logic [2:0] normal_integrator_limit;
		logic wake_en;
		logic scope_sync_en;
		logic strongest_key_suppress_en;
		logic [1:0] burst_len_code;
		logic [7:0] neg_recal_delay;
	} tsv_key_cfg_t;

	typedef struct packed {
		logic [4:0] keyIdx;
		logic drivePulse;
		logic receiveEn;
	} tsv_drive_t;

	typedef enum logic [2:0] {
		SEQ_SLEEP,
		SEQ_SYNC_WAIT,
		SEQ_LAUNCH,
		SEQ_BURST,
		SEQ_DONE
	} tsv_seq_t;
endpackage

// *** logic/tsv_touch_scan_supervisor.sv ***
`include "tsv_defines.svh"

module tsv_touch_scan_supervisor #(
	parameter int NKEYS = 16,
	parameter int DW = 16,
	parameter int TICK_CYCLES = `TSV_TICK_NS / `TSV_CLK_NS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NKEYS-1:0] keyDetect,
	input wire logic [NKEYS-1:0] keyAbovePos,
	input wire logic [NKEYS-1:0] keyBelowNeg,
	input wire logic [NKEYS*DW-1:0] keyDeltaFlat,
	input wire logic mainsSync,
	output tsv_pkg::tsv_drive_t drive,
	output logic scopeSync,
	output logic scanDone,
	output logic [NKEYS-1:0] keyState,
	output logic changeOut,
	output logic fastMode,
	output logic [NKEYS-1:0] recalPulse,
	output logic [NKEYS-1:0] driftEn
);
	localparam int KW = $clog2(NKEYS);

	function automatic logic signed [DW-1:0] deltaOf(input logic [NKEYS*DW-1:0] f, input int i);
		return f[i*DW +: DW];
	endfunction

	function automatic logic [KW:0] nextEnabled(input logic [NKEYS-1:0] en, input int from);
		logic [KW:0] r;
		r = (KW+1)'(NKEYS);
		for (int i = NKEYS - 1; i >= 0; i--) begin
			if (i >= from && en[i]) begin
				r = (KW+1)'(i);
			end
		end
		return r;
	endfunction

	function automatic logic cfgHit(input logic [11:0] a);
		return a[11:8] == `TSV_ADDR_KEYCFG_PAGE && a[1:0] == 2'b00 && int'(a[7:2]) < NKEYS;
	endfunction

	function automatic logic isMapped(input logic [11:0] a);
		return cfgHit(a) || a == `TSV_ADDR_CTRL || a == `TSV_ADDR_AWAKE || a == `TSV_ADDR_DRIFT_HOLD
			|| a == `TSV_ADDR_STATUS || a == `TSV_ADDR_KEYSTATE || a == `TSV_ADDR_RECAL;
	endfunction

	function automatic logic [16:0] sleepMs(input logic [2:0] idx);
		case (idx)
			3'h0: return `TSV_SLEEP0_MS;
			3'h1: return `TSV_SLEEP1_MS;
			3'h2: return `TSV_SLEEP2_MS;
			3'h3: return `TSV_SLEEP3_MS;
			3'h4: return `TSV_SLEEP4_MS;
			3'h5: return `TSV_SLEEP5_MS;
			3'h6: return `TSV_SLEEP6_MS;
			default: return `TSV_SLEEP7_MS;
		endcase
	endfunction

	tsv_pkg::tsv_key_cfg_t cfg_r [NKEYS];
	logic [7:0] ctrl_r;
	logic [7:0] awake_r;
	logic [7:0] holdTime_r;
	logic [NKEYS-1:0] hostRecal_r;
	logic [31:0] rdata_r;
	logic [31:0] rdVal;
	logic wrEn;
	logic rdKeyState;
	logic [KW-1:0] cfgIdx;
	logic mainsEn;
	logic shiftMode;

	// apb slave, zero wait states, read data captured in setup cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(paddr);
	assign prdata = rdata_r;
	assign wrEn = psel & penable & pwrite & isMapped(paddr);
	assign rdKeyState = psel & penable & ~pwrite & paddr == `TSV_ADDR_KEYSTATE;
	assign cfgIdx = paddr[KW+1:2];
	assign mainsEn = ctrl_r[`TSV_CTRL_MAINS_BIT];
	assign shiftMode = ctrl_r[`TSV_CTRL_SHIFT_BIT];

	logic [16:0] holdCnt_r;
	logic fast_r;
	logic changeOut_r;
	logic [NKEYS-1:0] keyState_r;

	always_comb begin
		rdVal = 32'h0;
		if (cfgHit(paddr)) begin
			rdVal = {16'h0, cfg_r[cfgIdx]};
		end else begin
			case (paddr)
				`TSV_ADDR_CTRL: rdVal = {24'h0, ctrl_r};
				`TSV_ADDR_AWAKE: rdVal = {24'h0, awake_r};
				`TSV_ADDR_DRIFT_HOLD: rdVal = {24'h0, holdTime_r};
				`TSV_ADDR_STATUS: rdVal = {29'h0, changeOut_r, holdCnt_r != 17'h0, fast_r};
				`TSV_ADDR_KEYSTATE: rdVal = 32'(keyState_r);
				default: rdVal = 32'h0;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rdata_r <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			rdata_r <= rdVal;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ctrl_r <= `TSV_CTRL_RST;
			awake_r <= `TSV_AWAKE_RST;
			holdTime_r <= `TSV_DRIFT_HOLD_RST;
			for (int k = 0; k < NKEYS; k++) begin
				cfg_r[k] <= `TSV_KEYCFG_RST;
			end
		end else if (wrEn) begin
			if (cfgHit(paddr)) begin
				cfg_r[cfgIdx] <= pwdata[15:0];
				if (pwdata[7:0] == `TSV_NEG_RECAL_ILLEGAL) begin
					cfg_r[cfgIdx].neg_recal_delay <= `TSV_NEG_RECAL_MAX;
				end
			end else begin
				case (paddr)
					`TSV_ADDR_CTRL: ctrl_r <= {3'h0, pwdata[4:0]};
					`TSV_ADDR_AWAKE: awake_r <= pwdata[7:0];
					`TSV_ADDR_DRIFT_HOLD: holdTime_r <= pwdata[7:0];
					default: ctrl_r <= ctrl_r;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hostRecal_r <= '0;
		end else if (wrEn && paddr == `TSV_ADDR_RECAL) begin
			hostRecal_r <= pwdata[NKEYS-1:0];
		end else begin
			hostRecal_r <= '0;
		end
	end

	// common 1 ms time base
	logic [$clog2(TICK_CYCLES+1)-1:0] pre_r;
	logic tick;
	assign tick = pre_r == '0;

	always_ff @(posedge ref_clk) begin
		if (!rst_b || tick) begin
			pre_r <= ($clog2(TICK_CYCLES+1))'(TICK_CYCLES - 1);
		end else begin
			pre_r <= pre_r - 1'b1;
		end
	end

	// strongest deviation suppression and reported key state
	logic [NKEYS-1:0] supp;
	logic [NKEYS-1:0] keyState_nxt;

	always_comb begin
		for (int k = 0; k < NKEYS; k++) begin
			supp[k] = 1'b0;
			for (int j = 0; j < NKEYS; j++) begin
				if (j != k && cfg_r[k].strongest_key_suppress_en && cfg_r[j].strongest_key_suppress_en
					&& deltaOf(keyDeltaFlat, j) < deltaOf(keyDeltaFlat, k)) begin
					supp[k] = 1'b1;
				end
			end
		end
		keyState_nxt = keyDetect & ~supp;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			keyState_r <= '0;
		end else begin
			keyState_r <= keyState_nxt;
		end
	end

	assign keyState = keyState_r;

	// recalibration timers
	logic [16:0] negTmr_r [NKEYS];
	logic [16:0] posTmr_r [NKEYS];
	logic [NKEYS-1:0] recalNxt;
	logic [NKEYS-1:0] recal_r;

	always_comb begin
		for (int k = 0; k < NKEYS; k++) begin
			recalNxt[k] = hostRecal_r[k]
				|| (keyDetect[k] && cfg_r[k].neg_recal_delay != 8'h0
				&& negTmr_r[k] >= 17'(cfg_r[k].neg_recal_delay) * `TSV_NEG_RECAL_UNIT_MS)
				|| (keyAbovePos[k] && posTmr_r[k] >= `TSV_POS_RECAL_MS);
		end
	end

	always_ff @(posedge ref_clk) begin
		for (int k = 0; k < NKEYS; k++) begin
			if (!rst_b || !keyDetect[k] || recalNxt[k]) begin
				negTmr_r[k] <= 17'h0;
			end else if (tick && negTmr_r[k] != 17'h1ffff) begin
				negTmr_r[k] <= negTmr_r[k] + 17'h1;
			end
			if (!rst_b || !keyAbovePos[k] || recalNxt[k]) begin
				posTmr_r[k] <= 17'h0;
			end else if (tick && posTmr_r[k] < `TSV_POS_RECAL_MS) begin
				posTmr_r[k] <= posTmr_r[k] + 17'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			recal_r <= '0;
		end else begin
			recal_r <= recalNxt;
		end
	end

	assign recalPulse = recal_r;

	// drift hold after any new detection
	logic [NKEYS-1:0] detPrev_r;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			detPrev_r <= '0;
			holdCnt_r <= 17'h0;
		end else begin
			detPrev_r <= keyDetect;
			if (|(keyDetect & ~detPrev_r) && holdTime_r != 8'h0) begin
				holdCnt_r <= 17'(holdTime_r) * `TSV_TIME_UNIT_MS;
			end else if (tick && holdCnt_r != 17'h0) begin
				holdCnt_r <= holdCnt_r - 17'h1;
			end
		end
	end

	assign driftEn = ~keyBelowNeg & {NKEYS{holdCnt_r == 17'h0}};

	// awake timeout and change output
	logic [NKEYS-1:0] changed;
	logic [NKEYS-1:0] wakeMask;
	logic wakeHit;
	logic [16:0] awakeLoad;
	logic [16:0] awakeCnt_r;

	always_comb begin
		changed = keyState_nxt ^ keyState_r;
		for (int k = 0; k < NKEYS; k++) begin
			wakeMask[k] = shiftMode | cfg_r[k].wake_en;
		end
		wakeHit = |(changed & wakeMask);
		if (shiftMode) begin
			awakeLoad = `TSV_SHIFT_AWAKE_MS;
		end else if (awake_r == 8'h0) begin
			awakeLoad = `TSV_TIME_UNIT_MS;
		end else begin
			awakeLoad = 17'(awake_r) * `TSV_TIME_UNIT_MS;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			fast_r <= 1'b0;
			awakeCnt_r <= 17'h0;
		end else if (wakeHit || (fast_r && |changed)) begin
			fast_r <= 1'b1;
			awakeCnt_r <= awakeLoad;
		end else if (tick && fast_r) begin
			if (awakeCnt_r <= 17'h1) begin
				fast_r <= 1'b0;
				awakeCnt_r <= 17'h0;
			end else begin
				awakeCnt_r <= awakeCnt_r - 17'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			changeOut_r <= 1'b0;
		end else if (wakeHit && !shiftMode) begin
			changeOut_r <= 1'b1;
		end else if (rdKeyState || shiftMode) begin
			changeOut_r <= 1'b0;
		end
	end

	assign changeOut = changeOut_r;
	assign fastMode = fast_r;

	// scan sequencer
	tsv_pkg::tsv_seq_t state_r;
	logic [KW-1:0] curKey_r;
	logic [6:0] burstCnt_r;
	logic phase_r;
	logic [16:0] seqCnt_r;
	logic mainsPrev_r;
	logic mainsFall;
	logic [NKEYS-1:0] keyEn;
	logic [KW:0] firstKey;
	logic [KW:0] nextKey;
	logic [6:0] lenM1;

	always_comb begin
		for (int k = 0; k < NKEYS; k++) begin
			keyEn[k] = cfg_r[k].normal_integrator_limit != 3'h0;
		end
		firstKey = nextEnabled(keyEn, 0);
		nextKey = nextEnabled(keyEn, int'(curKey_r) + 1);
		lenM1 = (7'(cfg_r[curKey_r].burst_len_code) + 7'd1) * `TSV_BURST_UNIT - 7'd1;
	end

	assign mainsFall = mainsPrev_r & ~mainsSync;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mainsPrev_r <= 1'b1;
		end else begin
			mainsPrev_r <= mainsSync;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			state_r <= tsv_pkg::SEQ_SLEEP;
			curKey_r <= '0;
			burstCnt_r <= 7'h0;
			phase_r <= 1'b0;
			seqCnt_r <= 17'h0;
		end else begin
			case (state_r)
				tsv_pkg::SEQ_SLEEP: begin
					if (fast_r || seqCnt_r == 17'h0) begin
						seqCnt_r <= `TSV_MAINS_WAIT_MS;
						state_r <= mainsEn ? tsv_pkg::SEQ_SYNC_WAIT : tsv_pkg::SEQ_LAUNCH;
					end else if (tick) begin
						seqCnt_r <= seqCnt_r - 17'h1;
					end
				end
				tsv_pkg::SEQ_SYNC_WAIT: begin
					if (mainsFall || seqCnt_r == 17'h0) begin
						state_r <= tsv_pkg::SEQ_LAUNCH;
					end else if (tick) begin
						seqCnt_r <= seqCnt_r - 17'h1;
					end
				end
				tsv_pkg::SEQ_LAUNCH: begin
					burstCnt_r <= 7'h0;
					phase_r <= 1'b0;
					if (firstKey >= (KW+1)'(NKEYS)) begin
						state_r <= tsv_pkg::SEQ_DONE;
					end else begin
						curKey_r <= firstKey[KW-1:0];
						state_r <= tsv_pkg::SEQ_BURST;
					end
				end
				tsv_pkg::SEQ_BURST: begin
					phase_r <= ~phase_r;
					if (phase_r) begin
						if (burstCnt_r >= lenM1) begin
							burstCnt_r <= 7'h0;
							if (nextKey >= (KW+1)'(NKEYS)) begin
								state_r <= tsv_pkg::SEQ_DONE;
							end else begin
								curKey_r <= nextKey[KW-1:0];
							end
						end else begin
							burstCnt_r <= burstCnt_r + 7'h1;
						end
					end
				end
				tsv_pkg::SEQ_DONE: begin
					if (fast_r) begin
						seqCnt_r <= `TSV_MAINS_WAIT_MS;
						state_r <= mainsEn ? tsv_pkg::SEQ_SYNC_WAIT : tsv_pkg::SEQ_LAUNCH;
					end else begin
						seqCnt_r <= sleepMs(ctrl_r[3:1]);
						state_r <= tsv_pkg::SEQ_SLEEP;
					end
				end
				default: state_r <= tsv_pkg::SEQ_SLEEP;
			endcase
		end
	end

	assign drive.keyIdx = 5'(curKey_r);
	assign drive.receiveEn = state_r == tsv_pkg::SEQ_BURST;
	assign drive.drivePulse = state_r == tsv_pkg::SEQ_BURST && phase_r;
	assign scopeSync = state_r == tsv_pkg::SEQ_BURST && cfg_r[curKey_r].scope_sync_en;
	assign scanDone = state_r == tsv_pkg::SEQ_DONE;
endmodule

// *** dv/tsv_supervisor_monitor.sv ***
module tsv_supervisor_monitor #(parameter int NKEYS = 16, parameter int DW = 16,
	parameter int TICK_CYCLES = 4) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NKEYS-1:0] keyDetect,
	input wire logic [NKEYS-1:0] keyAbovePos,
	input wire logic [NKEYS-1:0] keyBelowNeg,
	input wire logic [NKEYS*DW-1:0] keyDeltaFlat,
	input wire logic mainsSync,
	input wire tsv_pkg::tsv_drive_t drive,
	input wire logic scopeSync,
	input wire logic scanDone,
	input wire logic [NKEYS-1:0] keyState,
	input wire logic changeOut,
	input wire logic fastMode,
	input wire logic [NKEYS-1:0] recalPulse,
	input wire logic [NKEYS-1:0] driftEn
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);
	a_err_unmapped: assert property (psel && penable && paddr > 12'h017 && paddr < 12'h100
		|-> pslverr && (pwrite || prdata == '0)) else $error("unmapped access not refused");
	a_pulse_inside: assert property (drive.drivePulse |-> drive.receiveEn)
		else $error("drive pulse outside burst");
	a_burst_start: assert property ($rose(drive.receiveEn) |->
		!drive.drivePulse ##1 drive.drivePulse) else $error("burst start wrong");
	a_pulse_once: assert property (drive.drivePulse |=> !drive.drivePulse)
		else $error("drive pulse too long");
	a_idx_steady: assert property (drive.receiveEn && $past(drive.receiveEn)
		&& !$past(drive.drivePulse) |-> $stable(drive.keyIdx)) else $error("key moved mid pulse");
	a_scope_inside: assert property (scopeSync |-> drive.receiveEn)
		else $error("scope sync outside burst");
	a_drift_neg: assert property ((driftEn & keyBelowNeg) == '0)
		else $error("drift on detected key");
	a_drift_hold: assert property ((keyDetect & ~$past(keyDetect)) != '0
		|-> ##2 driftEn == '0) else $error("drift not held");
	a_recal_single: assert property (recalPulse != '0 |=>
		(recalPulse & $past(recalPulse)) == '0) else $error("recal pulse too long");
	a_state_detect: assert property ((keyState & ~$past(keyDetect)) == '0)
		else $error("key state without detection");
	a_change_fast: assert property ($rose(changeOut) |-> fastMode)
		else $error("change without fast mode");
	a_done_idle: assert property (scanDone |-> !drive.receiveEn)
		else $error("scan done inside burst");
	cover property ($rose(fastMode));
	cover property (recalPulse != '0);
	cover property (scanDone && !fastMode);
endmodule

bind tsv_touch_scan_supervisor tsv_supervisor_monitor #(.NKEYS(NKEYS), .DW(DW),
	.TICK_CYCLES(TICK_CYCLES)) tsv_supervisor_monitor_i (.ref_clk, .rst_b, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .keyDetect, .keyAbovePos,
	.keyBelowNeg, .keyDeltaFlat, .mainsSync, .drive, .scopeSync, .scanDone, .keyState,
	.changeOut, .fastMode, .recalPulse, .driftEn);

// *** dv/tsv_key_matrix.sv ***
module tsv_key_matrix #(parameter int NKEYS = 5) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [NKEYS-1:0] touch,
	input wire logic [NKEYS-1:0] above,
	input wire logic [NKEYS-1:0] recalPulse,
	input wire logic syncLine,
	output logic [NKEYS-1:0] keyDetect,
	output logic [NKEYS-1:0] keyAbovePos,
	output logic [NKEYS-1:0] keyBelowNeg,
	output logic mainsSync
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [NKEYS-1:0] recalled_r;
	always_ff @(posedge ref_clk) begin
		if (!rst_b)
			recalled_r <= '0;
		else
			recalled_r <= (recalled_r | recalPulse) & (touch | above);
	end
	// reference reload clears the key until released
	assign keyDetect = touch & ~recalled_r;
	assign keyBelowNeg = keyDetect;
	assign keyAbovePos = above & ~recalled_r;
	// clean logic level, only its falling edge matters
	assign mainsSync = syncLine;
endmodule

// *** dv/tsv_touch_scan_supervisor_bench.sv ***
module tsv_touch_scan_supervisor_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NK = 5;
	localparam int TK = 4;
	localparam logic [15:0] CFG [5] = '{16'h5c01, 16'h10ff, 16'h5614, 16'h4714, 16'h5100};
	localparam int SLP [8] = '{16, 32, 64, 125, 250, 500, 1000, 2000};
	localparam logic [4:0] SUP = 5'b01101;
	logic ref_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, syncLine = 1;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, mainsSync, scopeSync, scanDone, changeOut, fastMode, seen4;
	logic [NK-1:0] keyDetect, keyAbovePos, keyBelowNeg, keyState, recalPulse, driftEn, tm, e;
	logic [NK-1:0] touch = '0, above = '0;
	logic [NK*16-1:0] keyDeltaFlat = '0;
	logic signed [15:0] dl [NK];
	logic [2:0] ev;
	tsv_pkg::tsv_drive_t drive;
	logic [32:0] expQ [$];
	int miscompares = 0, comparisons = 0, seed = 9373, g, tNeg, tPos;
	always #25 ref_clk = ~ref_clk;
	assign ev = {~fastMode, drive.receiveEn, scanDone};
	tsv_touch_scan_supervisor #(.NKEYS(NK), .TICK_CYCLES(TK)) tsv_touch_scan_supervisor_i (
		.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .keyDetect, .keyAbovePos, .keyBelowNeg, .keyDeltaFlat, .mainsSync, .drive,
		.scopeSync, .scanDone, .keyState, .changeOut, .fastMode, .recalPulse, .driftEn);
	tsv_key_matrix #(.NKEYS(NK)) tsv_key_matrix_i (.ref_clk, .rst_b, .touch, .above,
		.recalPulse, .syncLine, .keyDetect, .keyAbovePos, .keyBelowNeg, .mainsSync);
	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		expQ.push_back(x);
		apb(0, a, 0);
	endtask
	always @(posedge ref_clk) begin
		if (psel && penable && pready && !pwrite)
			chk({pslverr, prdata}, expQ.pop_front());
	end
	task automatic waitEvt(input int s, output int n);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (ev[s] !== 1'b1 && n < 20000);
	endtask
	task automatic near(input int n, input int x, input int t);
		chk(33'((n >= x - t && n <= x + t) ? x : n), 33'(x));
	endtask
	task automatic burst(input int k);
		int idx, n, sc, len;
		n = 0;
		sc = 0;
		len = 32 * (CFG[k][9:8] + 1);
		if (drive.receiveEn !== 1'b1)
			waitEvt(1, idx);
		idx = drive.keyIdx;
		while (drive.receiveEn === 1'b1 && drive.keyIdx === idx[4:0]) begin
			n++;
			sc += scopeSync;
			@(negedge ref_clk);
		end
		chk(33'(idx), 33'(k));
		chk(33'(n), 33'(len));
		chk(33'(sc), k == 0 ? 33'(len) : 33'd0);
	endtask
	initial begin
		cyc(3);
		rst_b <= 1;
		rd(12'h000, 33'h06);
		rd(12'h004, 33'h19);
		rd(12'h008, 33'h0a);
		rd(12'h100, 33'h5214);
		rd(12'h020, 33'h100000000);
		for (int k = 0; k < NK; k++)
			apb(1, 12'h100 + 12'(4 * k), 32'(CFG[k]));
		rd(12'h104, 33'h10fe);
		waitEvt(0, g);
		burst(0);
		burst(2);
		burst(3);
		burst(4);
		apb(1, 12'h000, 32'h1);
		waitEvt(0, g);
		waitEvt(1, g);
		near(g, 116 * TK + 2, 2 * TK + 4);
		waitEvt(0, g);
		cyc(150);
		syncLine <= 0;
		waitEvt(1, g);
		near(g, 3, 3);
		waitEvt(0, g);
		cyc(150);
		syncLine <= 1;
		waitEvt(1, g);
		near(g + 150, 116 * TK + 2, 2 * TK + 4);
		for (int i = 0; i < 8; i++) begin
			apb(1, 12'h000, 32'(i << 1));
			waitEvt(0, g);
			waitEvt(1, g);
			near(g, SLP[i] * TK + 2, TK + 3);
		end
		apb(1, 12'h000, 32'h0);
		apb(1, 12'h008, 32'h1);
		apb(1, 12'h004, 32'h1);
		touch[0] <= 1;
		cyc(5);
		@(negedge ref_clk);
		chk(33'({fastMode, changeOut}), 33'h3);
		waitEvt(0, g);
		waitEvt(1, g);
		near(g, 2, 2);
		rd(12'h010, 33'h1);
		@(negedge ref_clk);
		chk(33'(changeOut), 33'h0);
		cyc(1);
		touch[0] <= 0;
		cyc(300);
		touch[3] <= 1;
		waitEvt(2, g);
		near(g, 100 * TK + 2, 2 * TK + 2);
		cyc(1);
		touch[3] <= 0;
		cyc(50);
		@(negedge ref_clk);
		chk(33'(fastMode), 33'h0);
		cyc(1);
		touch[2] <= 1;
		cyc(300);
		@(negedge ref_clk);
		chk(33'(driftEn), 33'h0);
		cyc(120);
		@(negedge ref_clk);
		chk(33'(driftEn), 33'h1b);
		cyc(1);
		touch <= 5'b10001;
		above <= 5'b00100;
		tNeg = 0;
		tPos = 0;
		seen4 = 0;
		for (int c = 1; c <= 2200; c++) begin
			@(negedge ref_clk);
			tNeg = (tNeg == 0 && recalPulse[0] === 1'b1) ? c : tNeg;
			tPos = (tPos == 0 && recalPulse[2] === 1'b1) ? c : tPos;
			seen4 = seen4 | recalPulse[4];
		end
		near(tNeg, 500 * TK, 2 * TK + 2);
		near(tPos, 200 * TK, 2 * TK + 2);
		chk(33'(seen4), 33'h0);
		apb(1, 12'h014, 32'h10);
		cyc(1);
		@(negedge ref_clk);
		chk(33'(recalPulse), 33'h10);
		cyc(3);
		@(negedge ref_clk);
		chk(33'(keyState), 33'h0);
		waitEvt(2, g);
		apb(1, 12'h000, 32'h10);
		touch <= 5'b01000;
		above <= '0;
		rd(12'h00c, 33'h3);
		waitEvt(2, g);
		near(g, 2500 * TK, 2 * TK + 4);
		chk(33'(changeOut), 33'h0);
		apb(1, 12'h000, 32'h0);
		cyc(1);
		touch <= '0;
		above <= '0;
		for (int t = 0; t < 8; t++) begin
			tm = 5'($random(seed)) & 5'b11101;
			for (int k = 0; k < NK; k++)
				dl[k] = 16'($random(seed) % 64);
			e = tm;
			for (int k = 0; k < NK; k++)
				for (int j = 0; j < NK; j++)
					if (SUP[k] && SUP[j] && j != k && dl[j] < dl[k])
						e[k] = 0;
			cyc(1);
			touch <= tm;
			keyDeltaFlat <= {dl[4], dl[3], dl[2], dl[1], dl[0]};
			cyc(3);
			rd(12'h010, 33'(e));
		end
		give_verdict();
	end
	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		give_verdict();
	end
endmodule
